// ==== rtl/tsr_map.svh ====
/*
  Constants of the temperature readout block: timing, frame layout, reset values.
  Assumes a 125 MHz block clock; included by bare name before the package.
*/
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH

// clock rate in MHz
`define TSR_CLK_MHZ 125

// sequencer times in microseconds, as specified
`define TSR_IDLE_US 350
`define TSR_CONV_US 25

// derived cycle counts (exact integers at 125 MHz)
`define TSR_IDLE_CYCLES (`TSR_IDLE_US * `TSR_CLK_MHZ)
`define TSR_CONV_CYCLES (`TSR_CONV_US * `TSR_CLK_MHZ)

// serial frame layout
`define TSR_FRAME_BITS 16
`define TSR_SHIFT_FALLS 5'h0f
`define TSR_LOAD_FALL 5'h0e
`define TSR_LOAD_RISES 5'h0e
`define TSR_RISE_MAX 5'h10
`define TSR_RX_PD_POS 11
`define TSR_CTRL_PD_BIT 13

// reset values
`define TSR_RESULT_RST 10'h000
`define TSR_CTRL_RST 16'h0000
`define TSR_TIMER_RST 16'h0000

`endif

// ==== rtl/tsr_pkg.sv ====
/*
  Types of the temperature readout block: sequencer states and the state record.
  Assumes tsr_map.svh is compiled first where constants are needed.
*/
package tsr_pkg;

  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_CONV = 2'b10
  } tsr_seq_t;

  typedef struct packed {
    tsr_seq_t seq;
    logic [15:0] timer;
    logic lockout;
    logic shutdown;
    logic [9:0] result;
    logic [15:0] ctrl;
    logic sclkPrev;
    logic csActPrev;
    logic [15:0] txShift;
    logic [14:0] rxShift;
    logic [4:0] falls;
    logic [4:0] rises;
    logic dout;
    logic doutOe;
    logic convActive;
    logic oscRun;
  } tsr_state_t;

endpackage : tsr_pkg

// ==== rtl/tsr_sync.sv ====
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps

module tsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end

endmodule : tsr_sync

// ==== rtl/tsr_top.sv ====
/*
  Digital core of a self-timed temperature sensor with a slave serial port:
  conversion sequencer, result register, lockout, shutdown, control register.
  Assumes the analog converter delivers a settled 10-bit code on adcData by
  the end of each conversion window, and that the serial pins are asynchronous.
*/
`timescale 1ns/1ps
`include "tsr_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Auto-start a conversion when the 350 us idle timer expires in normal mode.
// - Each conversion lasts 25 us, then the converter powers down until next expiry or frame end.
// - Latest completed result is always available for serial readout.
// - Serial access overlapping a conversion sets a lockout blocking its result update.
// - Lockout clears only at next conversion start; stays set if selected then.
// - Shutdown stops the oscillator; no conversions until shutdown is left.
// - In shutdown the last result before shutdown is still read out.
// - End of each serial frame outside shutdown restarts the oscillator for a fresh conversion.
// - Leaving shutdown restarts the oscillator and a conversion.
// - Reads before a pending conversion completes return the previous whole result.
// - Result is 10-bit two's complement, 0.25 degree per step.
// - With the data input tied low the port still reads, never powers down.
// - Every frame reads the result; only a frame reaching the fifteenth falling edge writes the control register.
// - Serial clock is ignored while chip select is high.
// - A read is 16 clocks: leading zero then 10 result bits.
// - After the last bit the output holds until deselect, then floats.
// - Serial input is sampled on each of the first 16 rising serial clock edges of a frame.
// - Third received bit is power-down; first two bits are ignored.
// - Control bits load on the fifteenth falling edge; power-down acts then.
// - Deselect before the fifteenth edge leaves control and power state unchanged.
// - Serial output changes on the falling serial clock edge.
// - Result is shifted most significant bit first.
module tsr_top #(
  parameter int IDLE_CYCLES = `TSR_IDLE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial port pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic doutOe,
  // analog converter side
  input wire logic [9:0] adcData,
  output logic convActive,
  output logic oscRun,
  // status
  output logic shutdownMode,
  output logic resultLockout,
  output logic [9:0] temperatureResult,
  output logic [15:0] controlWord
);

  //////////////////////////////////////////////////////////////////////////////
  // constants

  localparam logic [15:0] IDLE_LAST = 16'(IDLE_CYCLES - 1);
  localparam logic [15:0] CONV_LAST = 16'(`TSR_CONV_CYCLES - 1);

  localparam tsr_pkg::tsr_state_t STATE_RST = '{
    seq: tsr_pkg::SEQ_CONV,
    timer: `TSR_TIMER_RST,
    lockout: 1'b0,
    shutdown: 1'b0,
    result: `TSR_RESULT_RST,
    ctrl: `TSR_CTRL_RST,
    sclkPrev: 1'b1,
    csActPrev: 1'b0,
    txShift: 16'h0000,
    rxShift: 15'h0000,
    falls: 5'h00,
    rises: 5'h00,
    dout: 1'b0,
    doutOe: 1'b0,
    convActive: 1'b1,
    oscRun: 1'b1
  };

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pinSync;
  logic csSyncN;
  logic sclkSync;
  logic dinSync;

  tsr_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h6)
  ) u_pin_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .asyncIn({csN, sclk, din}),
    .syncOut(pinSync)
  );

  assign csSyncN = pinSync[2];
  assign sclkSync = pinSync[1];
  assign dinSync = pinSync[0];

  //////////////////////////////////////////////////////////////////////////////
  // state

  tsr_pkg::tsr_state_t s_r;
  tsr_pkg::tsr_state_t s_nxt;

  logic csAct;
  logic frameStart;
  logic frameEnd;
  logic sclkRise;
  logic sclkFall;

  assign csAct = ~csSyncN;
  assign frameStart = csAct & ~s_r.csActPrev;
  assign frameEnd = ~csAct & s_r.csActPrev;
  // edges only count while selected
  assign sclkRise = csAct & s_r.csActPrev & sclkSync & ~s_r.sclkPrev;
  assign sclkFall = csAct & s_r.csActPrev & ~sclkSync & s_r.sclkPrev;

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic ctrlLoad;
    logic pdNew;
    ctrlLoad = 1'b0;
    pdNew = s_r.shutdown;
    s_nxt = s_r;
    s_nxt.sclkPrev = sclkSync;
    s_nxt.csActPrev = csAct;

    // serial shifter
    if (frameStart) begin
      // leading zero, result msb first, trailing zeros
      s_nxt.txShift = {1'b0, s_r.result, 5'h00};
      s_nxt.rxShift = 15'h0000;
      s_nxt.falls = 5'h00;
      s_nxt.rises = 5'h00;
      s_nxt.dout = 1'b0;
      s_nxt.doutOe = 1'b1;
    end else if (csAct) begin
      if (sclkRise && s_r.rises < `TSR_RISE_MAX) begin
        s_nxt.rxShift = {s_r.rxShift[13:0], dinSync};
        s_nxt.rises = s_r.rises + 5'h01;
      end
      if (sclkFall) begin
        if (s_r.falls < `TSR_SHIFT_FALLS) begin
          s_nxt.txShift = {s_r.txShift[14:0], 1'b0};
          s_nxt.dout = s_r.txShift[14];
          s_nxt.falls = s_r.falls + 5'h01;
        end
        // last bit is simply held from here on
        if (s_r.falls == `TSR_LOAD_FALL && s_r.rises == `TSR_LOAD_RISES) begin
          ctrlLoad = 1'b1;
        end
      end
    end else begin
      s_nxt.doutOe = 1'b0;
      s_nxt.dout = 1'b0;
    end

    // control register load; first two bits carried but unused
    // idle-high clock: fourteen bits are in at the fifteenth fall
    if (ctrlLoad) begin
      s_nxt.ctrl = {s_r.rxShift[13:0], 2'b00};
      pdNew = s_r.rxShift[`TSR_RX_PD_POS];
      s_nxt.shutdown = pdNew;
    end

    // conversion sequencer
    case (s_r.seq)
      tsr_pkg::SEQ_OFF: begin
        s_nxt.timer = `TSR_TIMER_RST;
      end
      tsr_pkg::SEQ_WAIT: begin
        if (s_r.timer == IDLE_LAST) begin
          s_nxt.seq = tsr_pkg::SEQ_CONV;
          s_nxt.timer = `TSR_TIMER_RST;
          s_nxt.lockout = csAct;
        end else begin
          s_nxt.timer = s_r.timer + 16'h0001;
        end
      end
      tsr_pkg::SEQ_CONV: begin
        if (csAct) begin
          s_nxt.lockout = 1'b1;
        end
        if (s_r.timer == CONV_LAST) begin
          if (!s_r.lockout && !csAct) begin
            s_nxt.result = adcData;
          end
          s_nxt.seq = tsr_pkg::SEQ_WAIT;
          s_nxt.timer = `TSR_TIMER_RST;
        end else begin
          s_nxt.timer = s_r.timer + 16'h0001;
        end
      end
      default: begin
        s_nxt.seq = tsr_pkg::SEQ_OFF;
        s_nxt.timer = `TSR_TIMER_RST;
      end
    endcase

    // frame end or wake-up restarts the oscillator
    if (frameEnd && !s_r.shutdown) begin
      s_nxt.seq = tsr_pkg::SEQ_CONV;
      s_nxt.timer = `TSR_TIMER_RST;
      s_nxt.lockout = 1'b0;
    end
    if (ctrlLoad && pdNew) begin
      s_nxt.seq = tsr_pkg::SEQ_OFF;
      s_nxt.timer = `TSR_TIMER_RST;
    end else if (ctrlLoad && s_r.shutdown) begin
      s_nxt.seq = tsr_pkg::SEQ_CONV;
      s_nxt.timer = `TSR_TIMER_RST;
      s_nxt.lockout = 1'b1;
    end

    s_nxt.convActive = (s_nxt.seq == tsr_pkg::SEQ_CONV);
    s_nxt.oscRun = (s_nxt.seq != tsr_pkg::SEQ_OFF);
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign dout = s_r.dout;
  assign doutOe = s_r.doutOe;
  assign convActive = s_r.convActive;
  assign oscRun = s_r.oscRun;
  assign shutdownMode = s_r.shutdown;
  assign resultLockout = s_r.lockout;
  assign temperatureResult = s_r.result;
  assign controlWord = s_r.ctrl;

endmodule : tsr_top

// ==== sim/tsr_checker.sv ====
/*
  Port checker of the temperature readout block.
  Assumes it is bound onto tsr_top and given the same IDLE_CYCLES.
*/
`timescale 1ns/1ps
`include "tsr_map.svh"

module tsr_checker #(
  parameter int IDLE_CYCLES = `TSR_IDLE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic dout,
  input wire logic doutOe,
  // sequencer and status
  input wire logic convActive,
  input wire logic oscRun,
  input wire logic shutdownMode,
  input wire logic resultLockout,
  input wire logic [9:0] temperatureResult,
  input wire logic [15:0] controlWord
);
  int idleCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      idleCnt <= 0;
    end else begin
      idleCnt <= convActive ? 0 : idleCnt + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  AST_OE_ON: assert property ($fell(csN) ##1 !csN [*4] |-> doutOe && !dout)
    else $error("output not enabled with leading zero");
  AST_OE_OFF: assert property ($rose(csN) ##1 csN [*4] |-> !doutOe && !dout)
    else $error("output not released after deselect");
  AST_IDLE_QUIET: assert property (csN [*6] |-> !doutOe && $stable(controlWord))
    else $error("activity while deselected");
  AST_DOUT_EDGE: assert property ((!csN && sclk) [*6] |=> $stable(dout))
    else $error("output changed without a falling clock");
  AST_SHUT_OSC: assert property (shutdownMode [*2] |-> !oscRun && !convActive)
    else $error("oscillator running in shutdown");
  AST_RES_HOLD: assert property (!convActive |=> $stable(temperatureResult))
    else $error("result changed outside a conversion");
  AST_LOCK_HOLD: assert property (resultLockout |=> $stable(temperatureResult))
    else $error("result changed under lockout");
  AST_LOCK_SET: assert property ((convActive && !csN) [*5] |-> resultLockout)
    else $error("lockout not set by access");
  AST_IDLE_LEN: assert property ($rose(convActive) && csN && $past(csN, 8) && oscRun
    |-> idleCnt >= IDLE_CYCLES - 1 && idleCnt <= IDLE_CYCLES + 1)
    else $error("idle interval length wrong");
  cover property ($rose(shutdownMode));
  cover property ($rose(resultLockout));
  cover property ($rose(csN));
endmodule : tsr_checker

bind tsr_top tsr_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.ref_clk, .reset_n, .csN, .sclk,
  .dout, .doutOe, .convActive, .oscRun, .shutdownMode, .resultLockout, .temperatureResult,
  .controlWord);

// ==== sim/tsr_master.sv ====
/*
  Serial master model: clock idles high, 64 ns period, bits sampled before each fall.
  Assumes frames are requested one at a time by the bench.
*/
`timescale 1ns/1ps

module tsr_master (
  // driven pins
  output logic csN,
  output logic sclk,
  output logic din,
  // observed pins
  input wire logic dout,
  input wire logic doutOe
);
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
    int i;
    rx = '0;
    #13.7 csN = 1'b0;
    #32;
    for (i = 0; i < n; i++) begin
      #32 rx[15 - i] = doutOe ? dout : ~dout;
      sclk = 1'b0;
      din = tx[15 - i];
      #32 sclk = 1'b1;
    end
    #32 csN = 1'b1;
    din = 1'b0;
    #64;
  endtask : frame
endmodule : tsr_master

// ==== sim/test_temp_sensor_autoconvert_serial_port.sv ====
/*
  Bench of the temperature readout block: reads, conversions, shutdown, partial frames.
  Assumes tsr_master as the serial master and a short idle interval of 200 cycles.
*/
`timescale 1ns/1ps

module test_temp_sensor_autoconvert_serial_port;
  logic ref_clk, reset_n, csN, sclk, din, dout, doutOe;
  logic convActive, oscRun, shutdownMode, resultLockout;
  logic [9:0] adcData, temperatureResult, prev;
  logic [15:0] controlWord, rx;
  logic [9:0] codes [5] = '{10'h200, 10'h3ff, 10'h001, 10'h1fc, 10'h000};
  int n_mismatch = 0;
  int cmp_count = 0;
  int i;
  tsr_top #(.IDLE_CYCLES(200)) uut (.ref_clk, .reset_n, .csN, .sclk, .din, .dout, .doutOe,
    .adcData, .convActive, .oscRun, .shutdownMode, .resultLockout, .temperatureResult,
    .controlWord);
  tsr_master m (.csN, .sclk, .din, .dout, .doutOe);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic rd(input logic [15:0] tx, input logic [9:0] exp);
    m.frame(tx, 16, rx);
    chk(rx, {1'b0, exp, 5'h00});
    cyc(1);
  endtask : rd
  task final_report;
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    n_mismatch++;
    final_report;
  end
  initial begin
    reset_n = 1'b0;
    adcData = 10'h064;
    cyc(12);
    reset_n = 1'b1;
    chk({6'h00, temperatureResult}, 16'h0000);
    chk({controlWord[14:0], shutdownMode}, 16'h0000);
    cyc(3400);
    chk({6'h00, temperatureResult}, 16'h0064);
    prev = 10'h064;
    for (i = 0; i < 5; i++) begin
      adcData = codes[i];
      rd(16'h0000, prev);
      cyc(3140);
      rd(16'h0000, codes[i]);
      prev = codes[i];
    end
    rd(16'he000, prev);
    chk(controlWord, 16'he000);
    chk({14'h0000, shutdownMode, oscRun}, 16'h0002);
    adcData = 10'h155;
    cyc(3300);
    rd(16'h2000, prev);
    m.frame(16'h0000, 14, rx);
    cyc(1);
    chk({15'h0000, shutdownMode}, 16'h0001);
    rd(16'h0000, prev);
    chk({14'h0000, shutdownMode, oscRun}, 16'h0001);
    cyc(3140);
    rd(16'h0000, 10'h155);
    m.frame(16'h2000, 14, rx);
    cyc(1);
    chk({15'h0000, shutdownMode}, 16'h0000);
    final_report;
  end
endmodule : test_temp_sensor_autoconvert_serial_port
